// [bench/rsc_src_model.sv]
// Model of the reset sources: reset pin, supply detectors, watchdog and debugger.
`default_nettype none
module rsc_src_model (
  input  wire logic       clk,
  input  wire logic [2:0] sel,
  input  wire logic       on,
  output logic            resetPin_n,
  output logic            porDetect,
  output logic            bodDetect,
  output logic            watchdogTimeout,
  output logic            debugResetReq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wdtHold = 2'h0;

  // The pin has a pull-up, so it idles high whenever nobody pulls it down.
  assign resetPin_n      = !(on && sel == 3'h0);
  assign bodDetect       = on && sel == 3'h1;
  assign porDetect       = on && sel == 3'h2;
  // A watchdog expiry is held three cycles longer so the synchroniser never misses it.
  assign watchdogTimeout = (on && sel == 3'h3) || wdtHold != 2'h0;
  // Only this debugger stand-in ever raises the debug reset request.
  assign debugResetReq   = on && sel == 3'h4;

  always_ff @(posedge clk) begin
    wdtHold <= (on && sel == 3'h3) ? 2'h3 : (wdtHold != 2'h0 ? wdtHold - 2'h1 : 2'h0);
  end
endmodule // rsc_src_model
`default_nettype wire

// [bench/rsc_system_reset_controller_tb.sv]
// Self-checking testbench of the system reset controller.
`default_nettype none
module rsc_system_reset_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         STEP = 4;
  localparam int         SCAN = 8;
  localparam logic [7:0] KEY  = 8'hA5;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest, on;
  logic sysResetActive, debugIfaceReset, fuseReload, bootDone;
  logic resetPin_n, porDetect, bodDetect, watchdogTimeout, debugResetReq;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [2:0]  sel;
  logic [3:0]  be;
  logic [7:0]  rd;
  rsc_pkg::rsc_fuse_s fuse;
  int mismatches, comparisons, reloads, dbgCyc;
  int lenPin, lenBod, lenDbg, lenNoScan;

  rsc_system_reset_controller #(.SUT_STEP_CYCLES(STEP), .SCAN_CYCLES(SCAN), .IO_REG_KEY(KEY))
  u_dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .resetPin_n(resetPin_n), .porDetect(porDetect), .bodDetect(bodDetect),
    .watchdogTimeout(watchdogTimeout), .debugResetReq(debugResetReq), .fuseIn(fuse),
    .sysResetActive(sysResetActive), .debugIfaceReset(debugIfaceReset),
    .fuseReload(fuseReload), .bootDone(bootDone));

  rsc_src_model u_src (.clk(clk), .sel(sel), .on(on), .resetPin_n(resetPin_n),
    .porDetect(porDetect), .bodDetect(bodDetect), .watchdogTimeout(watchdogTimeout),
    .debugResetReq(debugResetReq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (fuseReload === 1'b1) reloads++;
    if (debugIfaceReset === 1'b1) dbgCyc++;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hung(input int n);
    if (n >= 600) begin
      mismatches++;
      $display("BAD wait expected end seen none");
      wrap_up();
    end
  endtask

  // One Avalon transfer; request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 600);
    hung(n);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitIdle(output int n);
    n = 0;
    while (sysResetActive !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    hung(n);
  endtask

  // Holds one source for 20 cycles, then measures the release-to-run time.
  task automatic hit(input logic [2:0] s, output int len);
    int r0, d0;
    r0 = reloads;
    d0 = dbgCyc;
    sel <= s;
    on  <= 1'b1;
    repeat (20) @(posedge clk);
    chk("held", {7'h0, sysResetActive}, 8'h01);
    on <= 1'b0;
    waitIdle(len);
    chk("reload", 8'(reloads - r0), 8'h01);
    chk("dbgRst", {7'h0, dbgCyc != d0}, {7'h0, s == 3'h1 || s == 3'h2});
  endtask

  initial begin
    int n;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    be = 4'hF;
    sel = 3'h0;
    on = 1'b0;
    fuse = {1'b1, 3'h2, 1'b1};
    mismatches = 0;
    comparisons = 0;
    reloads = 0;
    dbgCyc = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    waitIdle(n);
    chk("boot", {7'h0, bootDone}, 8'h01);
    bus(1'b0, 3'h0, 8'h00);
    chk("flagsPor", rd, 8'h01);
    bus(1'b0, 3'h1, 8'h00);
    chk("softRd", rd, 8'h00);
    bus(1'b0, 3'h5, 8'h00);
    chk("unmapped", rd, 8'h00);
    bus(1'b1, 3'h0, 8'hC0);
    bus(1'b0, 3'h0, 8'h00);
    chk("zeroWr", rd, 8'h01);
    // A write whose low byte lane is off must leave the flags alone.
    be <= 4'hE;
    bus(1'b1, 3'h0, 8'h01);
    be <= 4'hF;
    bus(1'b0, 3'h0, 8'h00);
    chk("beOff", rd, 8'h01);
    bus(1'b1, 3'h0, 8'h01);
    bus(1'b0, 3'h0, 8'h00);
    chk("w1c", rd, 8'h00);
    bus(1'b1, 3'h1, 8'h01);
    repeat (6) @(posedge clk);
    chk("noKey", {7'h0, sysResetActive}, 8'h00);
    // The key opens four accesses; four reads use them up before the trigger.
    bus(1'b1, 3'h2, KEY);
    bus(1'b0, 3'h2, 8'h00);
    chk("window", rd, 8'h04);
    bus(1'b0, 3'h3, 8'h00);
    chk("status", rd, 8'h0D);
    bus(1'b0, 3'h0, 8'h00);
    chk("flagsA", rd, 8'h00);
    bus(1'b0, 3'h0, 8'h00);
    chk("flagsB", rd, 8'h00);
    bus(1'b1, 3'h1, 8'h01);
    repeat (6) @(posedge clk);
    chk("lateSw", {7'h0, sysResetActive}, 8'h00);
    bus(1'b1, 3'h2, KEY);
    bus(1'b1, 3'h1, 8'h01);
    n = 0;
    while (sysResetActive !== 1'b1 && n < 6) begin
      @(posedge clk);
      n++;
    end
    chk("swStart", {7'h0, sysResetActive}, 8'h01);
    waitIdle(n);
    bus(1'b0, 3'h0, 8'h00);
    chk("swFlag", rd, 8'h10);
    bus(1'b1, 3'h0, 8'h3F);
    hit(3'h0, lenPin);
    bus(1'b0, 3'h0, 8'h00);
    chk("pinFlag", rd, 8'h04);
    hit(3'h3, n);
    bus(1'b0, 3'h0, 8'h00);
    chk("wdtFlag", rd, 8'h0C);
    bus(1'b1, 3'h0, 8'h0C);
    hit(3'h4, lenDbg);
    bus(1'b0, 3'h0, 8'h00);
    chk("dbgFlag", rd, 8'h20);
    chk("userLen", 8'(lenDbg - lenPin), 8'h00);
    hit(3'h1, lenBod);
    bus(1'b0, 3'h0, 8'h00);
    chk("bodFlag", rd, 8'h22);
    chk("sutLen", 8'(lenBod - lenPin), 8'(2 * STEP));
    fuse.scanEn <= 1'b0;
    hit(3'h0, lenNoScan);
    chk("scanLen", 8'(lenPin - lenNoScan), 8'(SCAN));
    fuse.pinEn <= 1'b0;
    hit(3'h2, n);
    bus(1'b0, 3'h0, 8'h00);
    chk("porFlags", rd, 8'h01);
    sel <= 3'h0;
    on  <= 1'b1;
    repeat (10) @(posedge clk);
    chk("pinOff", {7'h0, sysResetActive}, 8'h00);
    on <= 1'b0;
    repeat (4) @(posedge clk);
    // A second power-up in mid-run must bring back the power-on flag alone.
    bus(1'b1, 3'h0, 8'h01);
    bus(1'b0, 3'h0, 8'h00);
    chk("porClr", rd, 8'h00);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("arstHeld", {7'h0, sysResetActive}, 8'h01);
    chk("arstDbg", {7'h0, debugIfaceReset}, 8'h01);
    arst_n <= 1'b1;
    waitIdle(n);
    chk("reboot", {7'h0, bootDone}, 8'h01);
    bus(1'b0, 3'h0, 8'h00);
    chk("arstFlags", rd, 8'h01);
    wrap_up();
  end
endmodule // rsc_system_reset_controller_tb
`default_nettype wire

// [src/rsc_consts.svh]
// Constants of the system reset controller: offsets, bit positions, reset values, timing.
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// =====================================================================
// Register indices; the byte address is four times the index.
`define RSC_IDX_FLAGS       3'h0
`define RSC_IDX_SOFT        3'h1
`define RSC_IDX_KEY         3'h2
`define RSC_IDX_STATUS      3'h3

// =====================================================================
// Field positions and reset values.
`define RSC_BIT_SOFT_TRIG   0
`define RSC_FLAGS_POR_VALUE 6'h01
`define RSC_UNLOCK_WINDOW   3'h4

// =====================================================================
// Timing.
`define RSC_CLK_PERIOD_NS   100
`define RSC_INIT_TIME_NS    1000
`define RSC_INIT_CYCLES     ((`RSC_INIT_TIME_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_SUT_STEP_NS     1000000
`define RSC_SUT_STEP_CYCLES (`RSC_SUT_STEP_NS / `RSC_CLK_PERIOD_NS)
`define RSC_SCAN_CYCLES     2048

`endif

// [src/rsc_pkg.sv]
// Types shared by the system reset controller.
`default_nettype none
package rsc_pkg;

  typedef enum logic [1:0] {RUN, HOLD, INIT} rsc_state_e;

  typedef struct packed {
    logic dbg;
    logic sw;
    logic wdt;
    logic pin;
    logic brownout_detector;
    logic por;
  } rsc_src_s;

  typedef struct packed {
    logic       pinEn;
    logic [2:0] startup_delay_setting;
    logic       scanEn;
  } rsc_fuse_s;

endpackage
`default_nettype wire

// [src/rsc_system_reset_controller.sv]
// System reset controller: merges reset sources, sequences init, keeps cause flags.
//
// The Avalon-MM register port was left to the implementer.
`include "rsc_consts.svh"
`default_nettype none
module rsc_system_reset_controller #(
  parameter int         CNT_W           = 20,
  parameter int         SUT_STEP_CYCLES = `RSC_SUT_STEP_CYCLES,
  parameter int         SCAN_CYCLES     = `RSC_SCAN_CYCLES,
  // Unlock key value is arbitrary.
  parameter logic [7:0] IO_REG_KEY      = 8'hA5
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              resetPin_n,
  input  wire logic              porDetect,
  input  wire logic              bodDetect,
  input  wire logic              watchdogTimeout,
  input  wire logic              debugResetReq,
  input  wire rsc_pkg::rsc_fuse_s fuseIn,
  output logic                   sysResetActive,
  output logic                   debugIfaceReset,
  output logic                   fuseReload,
  output logic                   bootDone
);

  // ===================================================================
  // Declarations
  rsc_pkg::rsc_state_e state;
  rsc_pkg::rsc_state_e next_state;
  rsc_pkg::rsc_src_s   srcActive;
  rsc_pkg::rsc_fuse_s  fuseLat;
  logic [4:0]          syncA;
  logic [4:0]          syncB;
  logic                ack;
  logic                acc;
  logic                wrAcc;
  logic [2:0]          idx;
  logic [5:0]          flags;
  logic [5:0]          clrMask;
  logic [5:0]          setMask;
  logic [2:0]          unlockCnt;
  logic                swReq;
  logic                anySrc;
  logic                supply;
  logic                supplyCause;
  logic                initDone;
  logic                initEntry;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    initLoad;

  // ===================================================================
  // Input synchronisers; order is pin_n, por, bod, watchdog, debug.
  // The controller sits on an always-on clock, so it keeps working in every sleep mode.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 5'h10;
      syncB <= 5'h10;
    end else begin
      syncA <= {resetPin_n, porDetect, bodDetect, watchdogTimeout, debugResetReq};
      syncB <= syncA;
    end
  end

  // ===================================================================
  // Reset source qualification
  always_comb begin
    srcActive     = '0;
    srcActive.por = syncB[3];
    srcActive.brownout_detector = syncB[2];
    srcActive.pin = fuseLat.pinEn & ~syncB[4];
    srcActive.wdt = syncB[1];
    srcActive.sw  = swReq;
    srcActive.dbg = syncB[0];
  end

  // The pin only counts once the latched fuse enables it.
  assign anySrc = (srcActive != '0);
  assign supply = srcActive.por | srcActive.brownout_detector;

  // ===================================================================
  // Avalon-MM slave: every access is answered on the second edge.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign acc             = (avs_read | avs_write) & ack;
  assign wrAcc           = avs_write & ack & avs_byteenable[0];
  assign idx             = avs_address[4:2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack) begin
      case (idx)
        `RSC_IDX_FLAGS:  avs_readdata <= {26'h0, flags};
        `RSC_IDX_SOFT:   avs_readdata <= 32'h0;
        `RSC_IDX_KEY:    avs_readdata <= {29'h0, unlockCnt};
        `RSC_IDX_STATUS: avs_readdata <= {28'h0, fuseLat.scanEn, fuseLat.pinEn,
                                          supplyCause, bootDone};
        default:         avs_readdata <= 32'h0;
      endcase
    end
  end

  // ===================================================================
  // Key unlock; the window counts accepted bus accesses as instructions.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unlockCnt <= 3'h0;
    end else if (wrAcc && idx == `RSC_IDX_KEY && avs_writedata[7:0] == IO_REG_KEY) begin
      unlockCnt <= `RSC_UNLOCK_WINDOW;
    end else if (acc && unlockCnt != 3'h0) begin
      unlockCnt <= unlockCnt - 3'h1;
    end
  end

  // A locked write to the soft reset register leaves it untouched.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      swReq <= 1'b0;
    end else begin
      swReq <= wrAcc && idx == `RSC_IDX_SOFT && unlockCnt != 3'h0 &&
               avs_writedata[`RSC_BIT_SOFT_TRIG];
    end
  end

  // ===================================================================
  // Reset sequencer
  assign initDone  = (state == rsc_pkg::INIT) && (next_state == rsc_pkg::RUN);
  assign initEntry = (state == rsc_pkg::HOLD) && (next_state == rsc_pkg::INIT);

  always_comb begin
    next_state = state;
    case (state)
      rsc_pkg::RUN: begin
        if (anySrc) begin
          next_state = rsc_pkg::HOLD;
        end
      end
      rsc_pkg::HOLD: begin
        if (!anySrc) begin
          next_state = rsc_pkg::INIT;
        end
      end
      rsc_pkg::INIT: begin
        if (anySrc) begin
          next_state = rsc_pkg::HOLD;
        end else if (cnt == '0) begin
          next_state = rsc_pkg::RUN;
        end
      end
      default: next_state = rsc_pkg::HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= rsc_pkg::HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Startup delay only follows a supply reset; the scan adds its own time.
  always_comb begin
    initLoad = CNT_W'(`RSC_INIT_CYCLES - 1);
    if (supplyCause || supply) begin
      initLoad = initLoad + CNT_W'(fuseIn.startup_delay_setting) * CNT_W'(SUT_STEP_CYCLES);
    end
    if (fuseIn.scanEn) begin
      initLoad = initLoad + CNT_W'(SCAN_CYCLES);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (initEntry) begin
      cnt <= initLoad;
    end else if (state == rsc_pkg::INIT && cnt != '0) begin
      cnt <= cnt - CNT_W'(1);
    end
  end

  // Power-up of this domain itself counts as a supply reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supplyCause <= 1'b1;
    end else if (supply) begin
      supplyCause <= 1'b1;
    end else if (initDone) begin
      supplyCause <= 1'b0;
    end
  end

  // ===================================================================
  // Reset outputs and fuse reload
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sysResetActive  <= 1'b1;
      debugIfaceReset <= 1'b1;
      fuseReload      <= 1'b0;
    end else begin
      sysResetActive  <= (next_state != rsc_pkg::RUN);
      debugIfaceReset <= (next_state != rsc_pkg::RUN) & (supply | supplyCause);
      fuseReload      <= initEntry;
    end
  end

  // Fuses are sampled fresh at the start of every initialization.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fuseLat <= '0;
    end else if (initEntry) begin
      fuseLat <= fuseIn;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bootDone <= 1'b0;
    end else if (srcActive.por) begin
      bootDone <= 1'b0;
    end else if (initDone) begin
      bootDone <= 1'b1;
    end
  end

  // ===================================================================
  // Reset cause flags; once boot is done, a source event wins over a clear in the same cycle.
  assign clrMask = (wrAcc && idx == `RSC_IDX_FLAGS) ? avs_writedata[5:0] : 6'h00;
  assign setMask = bootDone ? 6'(srcActive) : 6'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= `RSC_FLAGS_POR_VALUE;
    end else if (srcActive.por) begin
      flags <= `RSC_FLAGS_POR_VALUE;
    end else begin
      flags <= (flags & ~clrMask) | setMask;
    end
  end

  // ===================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_sw_start;
    (wrAcc && idx == `RSC_IDX_SOFT && unlockCnt != 3'h0 && avs_writedata[0])
      |-> ##2 sysResetActive;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("soft reset did not start");

  property p_src_hold;
    anySrc |=> sysResetActive;
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("reset released with source");

  property p_pin;
    (fuseLat.pinEn && !syncB[4]) |=> sysResetActive;
  endproperty
  a_pin: assert property (p_pin) else $error("pin low without reset");

  property p_por_flags;
    srcActive.por |=> (flags == 6'h01);
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("flags wrong after power-on");

  property p_w1c;
    (wrAcc && idx == `RSC_IDX_FLAGS && setMask == 6'h00 && !srcActive.por)
      |=> ((flags & $past(avs_writedata[5:0])) == 6'h00);
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_soft_reads_zero;
    (avs_read && ack && idx == `RSC_IDX_SOFT) |-> (avs_readdata == 32'h0);
  endproperty
  a_soft_reads_zero: assert property (p_soft_reads_zero) else $error("trigger read not 0");

  property p_rsvd;
    (avs_read && ack && idx == `RSC_IDX_FLAGS) |-> (avs_readdata[31:6] == 26'h0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag bits nonzero");

  property p_locked;
    (wrAcc && idx == `RSC_IDX_SOFT && unlockCnt == 3'h0) |=> !swReq;
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect");

  property p_init_min;
    (state == rsc_pkg::INIT && $past(state) == rsc_pkg::HOLD && !anySrc)
      |-> (state == rsc_pkg::INIT && !anySrc)[*8] or ##[1:8] anySrc;
  endproperty
  a_init_min: assert property (p_init_min) else $error("init too short");

  property p_dbg_supply;
    debugIfaceReset |-> (sysResetActive && supplyCause);
  endproperty
  a_dbg_supply: assert property (p_dbg_supply) else $error("debug reset outside reset");

  property p_fuse_in_reset;
    fuseReload |-> (sysResetActive && fuseLat == $past(fuseIn));
  endproperty
  a_fuse_in_reset: assert property (p_fuse_in_reset) else $error("fuse reload in run");

  property p_supply_dbg;
    (srcActive.por || srcActive.brownout_detector) |=> debugIfaceReset;
  endproperty
  a_supply_dbg: assert property (p_supply_dbg) else $error("debug not reset");

  property p_window;
    (wrAcc && idx == `RSC_IDX_KEY && avs_writedata[7:0] == IO_REG_KEY)
      |=> (unlockCnt == `RSC_UNLOCK_WINDOW);
  endproperty
  a_window: assert property (p_window) else $error("key did not open window");

  property p_sw_flag;
    (swReq && bootDone && !srcActive.por) |=> flags[4];
  endproperty
  a_sw_flag: assert property (p_sw_flag) else $error("soft reset flag not set");

  // Before the first full boot no cause other than power-on may appear.
  property p_boot_flags;
    !bootDone |=> ((flags[5:1] & ~$past(flags[5:1])) == 5'h00);
  endproperty
  a_boot_flags: assert property (p_boot_flags) else $error("early flag");

  c_sw_reset:  cover property (swReq ##[1:20] !sysResetActive);
  c_pin_reset: cover property (srcActive.pin ##1 sysResetActive);
  c_flag_clr:  cover property (wrAcc && idx == `RSC_IDX_FLAGS && clrMask != 6'h00);
  c_por_dbg:   cover property (srcActive.por ##1 debugIfaceReset);
  c_scan_init: cover property (initEntry && fuseIn.scanEn);

endmodule // rsc_system_reset_controller
`default_nettype wire
